// ==== verilog/csd_chip_select.sv ====
// Chip-select decode with boot select and per-bank register file
`timescale 1ns/1ps
`default_nettype none
module csd_chip_select #(
  parameter int BANKS = csd_pkg::NUM_BANKS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [csd_pkg::OFF_W-1:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic core_req,
  input wire logic [csd_pkg::ADDR_W-1:0] core_addr,
  input wire logic core_internal,
  input wire logic internal_to_external_route,
  output logic [BANKS-1:0] bank_select_n,
  output logic access_error,
  output logic access_done,
  output csd_pkg::csd_ctrl_type sel_ctrl,
  output logic global_mode
);

  if (BANKS != csd_pkg::NUM_BANKS)
  begin : g_bad_banks
    $error("csd_chip_select: register map serves exactly four banks");
  end

  localparam int HI_W = csd_pkg::HI_W;
  localparam int HI_LSB = csd_pkg::ADDR_W - HI_W;

  logic [HI_W-1:0] base_q [BANKS];
  logic [31:0] mask_q [BANKS];
  csd_pkg::csd_ctrl_type ctrl_q [BANKS];
  logic global_q;
  logic [31:0] rdata_q;
  logic [BANKS-1:0] sel_q;
  logic error_q;
  logic done_q;
  csd_pkg::csd_ctrl_type sel_ctrl_q;

  wire logic [BANKS-1:0] hit_base;
  wire logic [BANKS-1:0] hit_mask;
  wire logic [BANKS-1:0] hit_ctrl;
  wire logic [BANKS-1:0] match;
  wire logic wr_en;
  wire logic rd_en;
  wire logic any_hit;
  wire logic ext_req;
  wire logic single;
  wire logic boot_valid_set;
  wire logic [HI_W-1:0] addr_hi;
  logic [BANKS-1:0] sel_d;
  logic [31:0] rdata_d;
  csd_pkg::csd_ctrl_type ctrl_d;

  assign wr_en = reg_sel && reg_wr;
  assign rd_en = reg_sel && reg_rd;
  assign addr_hi = core_addr[csd_pkg::ADDR_W-1:HI_LSB];

  genvar gi;
  for (gi = 0; gi < BANKS; gi++)
  begin : g_bank
    assign hit_base[gi] = reg_offset == csd_pkg::BASE_OFF[gi];
    assign hit_mask[gi] = reg_offset == csd_pkg::MASK_OFF[gi];
    assign hit_ctrl[gi] = reg_offset == csd_pkg::CTRL_OFF[gi];

    csd_bank_match #(
      .HI_W(HI_W)
    ) u_match (
      .base_field(base_q[gi]),
      .mask_field(mask_q[gi][31:HI_LSB]),
      .bank_valid(mask_q[gi][csd_pkg::VALID_BIT]),
      .addr_hi(addr_hi),
      .hit(match[gi])
    );

    always_ff @(posedge sys_clk)
    begin
      if (!nrst)
      begin
        base_q[gi] <= csd_pkg::BASE_RST;
        mask_q[gi] <= csd_pkg::MASK_RST;
        ctrl_q[gi] <= (gi == csd_pkg::BOOT_BANK) ?
          csd_pkg::BOOT_CTRL_RST : csd_pkg::CTRL_RST;
      end
      else if (wr_en)
      begin
        if (hit_base[gi])
          base_q[gi] <= reg_wdata[31:HI_LSB];
        if (hit_mask[gi])
          mask_q[gi] <= reg_wdata & csd_pkg::MASK_RW;
        if (hit_ctrl[gi])
          ctrl_q[gi] <= reg_wdata[15:0];
      end
    end
  end

  assign any_hit = |{hit_base, hit_mask, hit_ctrl};

  // Only a write of one to bank 0's valid bit leaves global mode
  assign boot_valid_set = wr_en && hit_mask[csd_pkg::BOOT_BANK] &&
    reg_wdata[csd_pkg::VALID_BIT];

  // Reserved offsets and base and mask reserved bits read as zero; all registers read back
  always_comb
  begin
    rdata_d = csd_pkg::READ_ZERO;
    for (int i = 0; i < BANKS; i++)
    begin
      if (hit_base[i])
        rdata_d = {base_q[i], 16'h0000};
      if (hit_mask[i])
        rdata_d = mask_q[i];
      if (hit_ctrl[i])
        rdata_d = {16'h0000, ctrl_q[i]};
    end
  end

  // Internal cycles go outside only when the route bit asks for it
  assign ext_req = core_req &&
    (!core_internal || internal_to_external_route);
  assign single = csd_pkg::csd_one_hot(match);

  // Global mode uses no bank 0 decode: bank 0 base and mask reset to zero, valid bit clear
  always_comb
  begin
    sel_d = '0;
    ctrl_d = ctrl_q[csd_pkg::BOOT_BANK];
    if (global_q)
      sel_d[csd_pkg::BOOT_BANK] = 1'b1;
    else if (single)
      sel_d = match;
    for (int i = 0; i < BANKS; i++)
    begin
      if (!global_q && single && match[i])
        ctrl_d = ctrl_q[i];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      global_q <= 1'b1;
    else if (boot_valid_set)
      global_q <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rdata_q <= csd_pkg::READ_ZERO;
    else if (rd_en)
      rdata_q <= rdata_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sel_q <= '0;
      error_q <= 1'b0;
      done_q <= 1'b0;
      sel_ctrl_q <= csd_pkg::CTRL_RST;
    end
    else
    begin
      sel_q <= ext_req ? sel_d : '0;
      error_q <= ext_req && !global_q && !single;
      done_q <= ext_req;
      sel_ctrl_q <= ext_req ? ctrl_d : csd_pkg::CTRL_RST;
    end
  end

  assign reg_rdata = rdata_q;
  assign bank_select_n = ~sel_q;
  assign access_error = error_q;
  assign access_done = done_q;
  assign sel_ctrl = sel_ctrl_q;
  assign global_mode = global_q;

  sequence s_boot_valid_write;
    wr_en && hit_mask[csd_pkg::BOOT_BANK] && reg_wdata[csd_pkg::VALID_BIT];
  endsequence

  sequence s_ext_access;
    ext_req;
  endsequence

  property p_global_boot;
    @(posedge sys_clk) disable iff (!nrst)
    global_q && ext_req |=> !bank_select_n[csd_pkg::BOOT_BANK];
  endproperty
  a_global_boot: assert property (p_global_boot)
    else $error("boot select missing in global mode");

  property p_global_no_other;
    @(posedge sys_clk) disable iff (!nrst)
    global_q |=> (bank_select_n[BANKS-1:1] == '1) && !access_error;
  endproperty
  a_global_no_other: assert property (p_global_no_other)
    else $error("other select asserted in global mode");

  property p_leave_global;
    @(posedge sys_clk) disable iff (!nrst)
    s_boot_valid_write |=> !global_q;
  endproperty
  a_leave_global: assert property (p_leave_global)
    else $error("global mode kept after valid bit set");

  property p_boot_ctrl_reset;
    @(posedge sys_clk)
    !nrst |=> ctrl_q[csd_pkg::BOOT_BANK] == csd_pkg::BOOT_CTRL_RST &&
      global_q;
  endproperty
  a_boot_ctrl_reset: assert property (p_boot_ctrl_reset)
    else $error("bank 0 control reset value wrong");

  property p_stay_normal;
    @(posedge sys_clk) disable iff (!nrst)
    !global_q |=> !global_q [*3];
  endproperty
  a_stay_normal: assert property (p_stay_normal)
    else $error("global mode returned without reset");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (!nrst)
    rd_en && !any_hit |=> reg_rdata == csd_pkg::READ_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unassigned location read nonzero");

  property p_base_readback;
    @(posedge sys_clk) disable iff (!nrst)
    wr_en && hit_base[1] ##1 !wr_en ##1 rd_en && hit_base[1] && !wr_en
      |=> reg_rdata == ($past(reg_wdata, 3) & 32'hFFFF_0000);
  endproperty
  a_base_readback: assert property (p_base_readback)
    else $error("base register readback wrong");

  property p_error_nonsingle;
    @(posedge sys_clk) disable iff (!nrst)
    ext_req && !global_q && !csd_pkg::csd_one_hot(match)
      |=> access_error && bank_select_n == '1;
  endproperty
  a_error_nonsingle: assert property (p_error_nonsingle)
    else $error("error missing on zero or many matches");

  property p_single_select;
    @(posedge sys_clk) disable iff (!nrst)
    ext_req && !global_q && csd_pkg::csd_one_hot(match)
      |=> ~bank_select_n == $past(match) && !access_error;
  endproperty
  a_single_select: assert property (p_single_select)
    else $error("single match did not drive its select");

  property p_internal_quiet;
    @(posedge sys_clk) disable iff (!nrst)
    core_req && core_internal && !internal_to_external_route
      |=> bank_select_n == '1 && !access_done;
  endproperty
  a_internal_quiet: assert property (p_internal_quiet)
    else $error("internal access went external");

  property p_done_pulse;
    @(posedge sys_clk) disable iff (!nrst)
    s_ext_access |=> access_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("external access not acknowledged");

  property p_idle_quiet;
    @(posedge sys_clk) disable iff (!nrst)
    !ext_req |=> bank_select_n == '1 && !access_done && !access_error;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("select asserted without an external access");

endmodule : csd_chip_select
`default_nettype wire

// ==== verilog/csd_pkg.sv ====
// Constants, field layouts and types of the chip-select decode block
`default_nettype none
package csd_pkg;

  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 32;
  localparam int HI_W = 16;
  localparam int OFF_W = 8;
  localparam int BOOT_BANK = 0;
  localparam int VALID_BIT = 0;
  localparam int DISK_BANK = 2;
  localparam int CARD_BANK = 3;

  // Register offsets from the module base
  localparam logic [7:0] BASE_OFF [NUM_BANKS] = '{8'h80, 8'h8C, 8'h98, 8'hA4};
  localparam logic [7:0] MASK_OFF [NUM_BANKS] = '{8'h84, 8'h90, 8'h9C, 8'hA8};
  localparam logic [7:0] CTRL_OFF [NUM_BANKS] = '{8'h88, 8'h94, 8'hA2, 8'hAE};

  // Writable bits of a mask register: mask field, attribute bits, valid bit
  localparam logic [31:0] MASK_RW = 32'hFFFF_017F;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] spare_hi;
    logic [3:0] wait_count_bit;
    logic auto_acknowledge;
    logic [1:0] port_width_code;
    logic byte_enable_mode;
    logic burst_read_enable;
    logic burst_write_enable;
    logic [3:0] spare_lo;
  } csd_ctrl_type;

  // Boot bank control at reset: 15 waits, auto ack, 16-bit port, byte enables
  localparam csd_ctrl_type BOOT_CTRL_RST = 16'h3F40;

  // True when exactly one bit of a match vector is set
  function automatic logic csd_one_hot(input logic [NUM_BANKS-1:0] v);
    logic [NUM_BANKS-1:0] low;
    low = v - NUM_BANKS'(1);
    return (v != '0) && ((v & low) == '0);
  endfunction : csd_one_hot

endpackage : csd_pkg
`default_nettype wire

// ==== verilog/csd_bank_match.sv ====
// One bank's address compare with mask and valid gating
`timescale 1ns/1ps
`default_nettype none
module csd_bank_match #(
  parameter int HI_W = 16
) (
  input wire logic [HI_W-1:0] base_field,
  input wire logic [HI_W-1:0] mask_field,
  input wire logic bank_valid,
  input wire logic [HI_W-1:0] addr_hi,
  output logic hit
);

  if (HI_W < 1 || HI_W > 32)
  begin : g_bad_width
    $error("csd_bank_match: HI_W out of range");
  end

  wire logic [HI_W-1:0] differ;

  assign differ = (base_field ^ addr_hi) & ~mask_field;
  assign hit = bank_valid && (differ == '0);

endmodule : csd_bank_match
`default_nettype wire

// ==== verification/csd_ext_mem.sv ====
// Far-side memory model counting selected cycles
`timescale 1ns/1ps
`default_nettype none
module csd_ext_mem (
  input wire logic sys_clk,
  input wire logic [3:0] bank_select_n,
  output logic [31:0] sel_count
);
  initial sel_count = 32'h0000_0000;
  // Devices only answer while a select is low
  always @(posedge sys_clk)
  begin
    if (bank_select_n != 4'hF)
      sel_count <= sel_count + 32'h0000_0001;
  end
endmodule : csd_ext_mem
`default_nettype wire

// ==== verification/boot_chip_select_decode_tb.sv ====
// Self-checking bench of the chip-select decode block
`timescale 1ns/1ps
`default_nettype none
module boot_chip_select_decode_tb;
  localparam logic [7:0] HOLES [4] = '{8'h00, 8'h8A, 8'hA0, 8'hFC};
  logic sys_clk, nrst, reg_sel, reg_wr, reg_rd, core_req, core_internal;
  logic route, access_error, access_done, global_mode, glob;
  logic [7:0] reg_offset;
  logic [31:0] reg_wdata, reg_rdata, core_addr, sel_count, r;
  logic [3:0] bank_select_n;
  csd_pkg::csd_ctrl_type sel_ctrl;
  logic [15:0] base [4];
  logic [31:0] mask [4];
  logic [15:0] ctrl [4];
  int miscompares, comparisons, seed, n_acc;

  csd_chip_select u_csd_chip_select (.sys_clk, .nrst, .reg_sel, .reg_wr,
    .reg_rd, .reg_offset, .reg_wdata, .reg_rdata, .core_req, .core_addr,
    .core_internal, .internal_to_external_route(route), .bank_select_n,
    .access_error, .access_done, .sel_ctrl, .global_mode);
  csd_ext_mem u_csd_ext_mem (.sys_clk, .bank_select_n, .sel_count);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One longword access; strobes drop at the edge that takes it
  task automatic bus(input logic w, input logic [7:0] off,
                     input logic [31:0] d);
    @(posedge sys_clk);
    reg_sel <= 1'b1;
    reg_wr <= w;
    reg_rd <= !w;
    reg_offset <= off;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_sel <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : bus

  task automatic rst();
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    glob = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      base[i] = 16'h0000;
      mask[i] = 32'h0000_0000;
      ctrl[i] = (i == 0) ? 16'h3F40 : 16'h0000;
    end
  endtask : rst

  function automatic logic [7:0] offs(input int b, input int k);
    return (k == 0) ? csd_pkg::BASE_OFF[b] :
           (k == 1) ? csd_pkg::MASK_OFF[b] : csd_pkg::CTRL_OFF[b];
  endfunction : offs

  // Reserved bits are always written as zero
  task automatic wreg(input int b, input int k, input logic [31:0] d);
    d = d & ((k == 0) ? 32'hFFFF_0000 :
             (k == 1) ? csd_pkg::MASK_RW : 32'h0000_3FF0);
    if (k == 0)
      base[b] = d[31:16];
    else if (k == 1)
      mask[b] = d;
    else
      ctrl[b] = d[15:0];
    if (k == 1 && b == 0 && d[0])
      glob = 1'b0;
    bus(1'b1, offs(b, k), d);
  endtask : wreg

  task automatic rd(input int b, input int k);
    bus(1'b0, offs(b, k), 32'h0);
    chk(reg_rdata, (k == 0) ? {base[b], 16'h0000} : (k == 1) ? mask[b] :
        {16'h0000, ctrl[b]});
  endtask : rd

  task automatic acc(input logic [31:0] a, input logic intl);
    logic [3:0] m, e;
    logic [15:0] ec;
    logic err;
    m = 4'h0;
    ec = 16'h0000;
    for (int i = 0; i < 4; i++)
      m[i] = mask[i][0] && (((a[31:16] ^ base[i]) & ~mask[i][31:16]) == 0);
    if (glob)
      m = 4'h1;
    err = !glob && $countones(m) != 1 && !(intl && !route);
    if (err || (intl && !route))
      m = 4'h0;
    for (int i = 0; i < 4; i++)
      if (m[i])
        ec = ctrl[i];
    e = ~m;
    n_acc += (m != 4'h0);
    @(posedge sys_clk);
    core_req <= 1'b1;
    core_addr <= a;
    core_internal <= intl;
    @(posedge sys_clk);
    core_req <= 1'b0;
    #1;
    chk(bank_select_n, e);
    chk(access_error, err);
    if (!err)
      chk(sel_ctrl, ec);
    chk(access_done, !(intl && !route));
  endtask : acc

  initial
  begin
    seed = 2478;
    {nrst, reg_sel, reg_wr, reg_rd, core_req, core_internal} = 6'h00;
    route = 1'b0;
    reg_offset = 8'h00;
    reg_wdata = 32'h0000_0000;
    core_addr = 32'h0000_0000;
    rst();
    chk(global_mode, 1'b1);
    rd(0, 2);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, HOLES[i], 32'h0);
      chk(reg_rdata, 32'h0);
    end
    wreg(1, 1, 32'h0000_0001);
    wreg(0, 0, $random(seed));
    wreg(0, 1, $random(seed) & 32'hFFFF_FFFE);
    acc(32'h0000_1234, 1'b0);
    repeat (8) acc($random(seed), 1'b0);
    acc($random(seed), 1'b1);
    route = 1'b1;
    acc($random(seed), 1'b1);
    route = 1'b0;
    wreg(0, 1, 32'h0000_0001);
    chk(global_mode, 1'b0);
    acc({base[0], 16'h00A5}, 1'b0);
    for (int b = 1; b < 4; b++)
    begin
      wreg(b, 0, $random(seed));
      wreg(b, 1, ($random(seed) & 32'h00F0_017E) | 32'h1);
      wreg(b, 2, $random(seed));
    end
    wreg(1, 0, $random(seed));
    rd(1, 0);
    for (int b = 0; b < 4; b++)
      for (int k = 0; k < 3; k++)
        rd(b, k);
    // Near-miss addresses hit mask edges as well as exact bases
    repeat (40)
    begin
      r = $random(seed);
      acc({base[r[1:0]] ^ (r[31:16] & 16'h00FF), r[15:0]}, 1'b0);
    end
    wreg(3, 0, {base[2], 16'h0000});
    acc({base[2], 16'h0000}, 1'b0);
    wreg(0, 1, 32'h0000_0000);
    chk(global_mode, 1'b0);
    acc({base[0], 16'h0000}, 1'b0);
    rst();
    chk(global_mode, 1'b1);
    acc(32'hFFFF_0000, 1'b0);
    // Model counts a select one edge after it shows
    @(posedge sys_clk);
    #1;
    chk(sel_count, n_acc);
    conclude();
  end

  initial
  begin
    #1_000_000;
    miscompares++;
    conclude();
  end
endmodule : boot_chip_select_decode_tb
`default_nettype wire
